// File: design/stg_pkg.sv
// Purpose: shared constants for the supply tracking and noise gate register bank
// Assumes: byte-wide registers in page 0 of the control port
// Notes:   tap tables hold whole sample periods, four 4-bit entries indexed by code
package stg_pkg;
  localparam logic [7:0]  ADDR_SWITCH_DELAY = 8'h6A;
  localparam logic [7:0]  ADDR_RATE_GATE    = 8'h6B;
  localparam logic [7:0]  ADDR_THRESH_HI    = 8'h6C;
  localparam logic [7:0]  ADDR_THRESH_MID   = 8'h6D;
  localparam logic [7:0]  ADDR_THRESH_LO    = 8'h6E;
  localparam logic [7:0]  ADDR_HYST_HIGH    = 8'h6F;
  localparam logic [7:0]  ADDR_HYST_LOW     = 8'h70;
  localparam logic [7:0]  ADDR_TRACKING     = 8'h71;
  localparam logic [7:0]  ADDR_DAC_LIMITER  = 8'h73;

  localparam logic [7:0]  RST_SWITCH_DELAY  = 8'h12;
  localparam logic [7:0]  RST_RATE_GATE     = 8'h7B;
  localparam logic [23:0] RST_THRESHOLD     = 24'h00001A;
  localparam logic [7:0]  RST_HYST_HIGH     = 8'h00;
  localparam logic [7:0]  RST_HYST_LOW      = 8'h96;
  localparam logic [7:0]  RST_TRACKING      = 8'h02;
  localparam logic [7:0]  RST_DAC_LIMITER   = 8'h08;

  // writable bits of the mixed register; the rest read back their reset value
  localparam logic [7:0]  RATE_GATE_WMASK   = 8'h7C;
  localparam int          POS_CONVERT_EN    = 6;
  localparam int          POS_RATE_LSB      = 3;
  localparam int          POS_FINE_EN       = 2;
  localparam int          POS_TRACK_EN      = 7;
  localparam int          POS_POLARITY      = 6;
  localparam int          POS_DITHER_DIS    = 5;

  localparam logic [2:0]  RATE_48K          = 3'h4;
  localparam logic [2:0]  RATE_96K          = 3'h5;
  localparam logic [2:0]  RATE_ERROR        = 3'h7;
  localparam logic [4:0]  HEADROOM_MAX_CODE = 5'h10;
  localparam int          DELAY_DEPTH       = 16;

  // entries for codes 3h..0h, high nibble is code 3h
  localparam logic [15:0] BRIDGE_TAP_48_ON  = 16'h5678;
  localparam logic [15:0] BRIDGE_TAP_48_OFF = 16'h3456;
  localparam logic [15:0] BRIDGE_TAP_96_ON  = 16'h78AC;
  localparam logic [15:0] BRIDGE_TAP_96_OFF = 16'h4579;
  localparam logic [15:0] SIGNAL_TAP_48_ON  = 16'h5567;
  localparam logic [15:0] SIGNAL_TAP_48_OFF = 16'h3345;
  localparam logic [15:0] SIGNAL_TAP_96_ON  = 16'h68AC;
  localparam logic [15:0] SIGNAL_TAP_96_OFF = 16'h3579;

  function automatic logic [3:0] tap_pick(input logic [15:0] tbl, input logic [1:0] code);
    tap_pick = tbl[{code, 2'b00} +: 4];
  endfunction
endpackage

// File: design/stg_sample_delay.sv
// Purpose: delays a one-bit control event by a selectable count of sample periods
// Assumes: sample_strobe pulses once per audio sample
// Notes:   tap of zero is never used, tables start at three periods
`timescale 1ns/1ps
`default_nettype none
module stg_sample_delay (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       sample_strobe,
  input  wire logic       din,
  input  wire logic [3:0] tap,
  output logic            dout
);
  typedef struct packed {
    logic [stg_pkg::DELAY_DEPTH-1:0] line;
    logic                            out;
  } stg_delay_state_t;

  stg_delay_state_t st;
  stg_delay_state_t next_st;

  always_comb
  begin
    next_st = st;
    if (sample_strobe)
    begin
      next_st.line = {st.line[stg_pkg::DELAY_DEPTH-2:0], din};
      next_st.out  = st.line[4'(tap - 4'h1)];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      st <= '0;
    else
      st <= next_st;
  end

  assign dout = st.out;
endmodule
`default_nettype wire

// File: design/stg_gate_detect.sv
// Purpose: fine-resolution noise gate, closes after the level stays low for the hysteresis count
// Assumes: sample_level is the magnitude of the current sample, one value per sample_strobe
// Notes:   counter saturates at the hysteresis value, so a long silence never wraps
`timescale 1ns/1ps
`default_nettype none
module stg_gate_detect (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        sample_strobe,
  input  wire logic        enable,
  input  wire logic [23:0] sample_level,
  input  wire logic [23:0] threshold,
  input  wire logic [18:0] hyst_count,
  output logic             gate_closed
);
  typedef struct packed {
    logic [18:0] quiet;
    logic        closed;
  } stg_gate_state_t;

  stg_gate_state_t st;
  stg_gate_state_t next_st;

  always_comb
  begin
    next_st = st;
    if (!enable)
      next_st = '0;
    else if (sample_strobe)
    begin
      if (sample_level >= threshold)
        next_st = '0;
      else if (st.quiet >= hyst_count)
        next_st.closed = 1'b1;
      else
        next_st.quiet = st.quiet + 19'h00001;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      st <= '0;
    else
      st <= next_st;
  end

  assign gate_closed = st.closed;
endmodule
`default_nettype wire

// File: design/stg_regs.sv
// Purpose: page 0 registers for supply selection timing, noise gate, class-H tracking and DAC options
// Assumes: byte access from the control port decoder, page already selected, one access per cycle
// Notes:   read data is registered, one cycle after reg_rd_en
`timescale 1ns/1ps
`default_nettype none
module stg_regs (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr_en,
  input  wire logic [7:0]  reg_wr_data,
  input  wire logic        reg_rd_en,
  output logic [7:0]       reg_rd_data,
  input  wire logic        sample_strobe,
  input  wire logic        rate_detect_valid,
  input  wire logic [2:0]  rate_detect_code,
  input  wire logic [23:0] sample_level,
  input  wire logic        bridge_req_in,
  input  wire logic        low_voltage_req_in,
  input  wire logic        tracking_mod_in,
  input  wire logic        bop_src_high_rail,
  output logic             bridge_switch_out,
  output logic             supply_ctrl_out,
  output logic             tracking_active,
  output logic             gate_closed,
  output logic             low_rail_convert_req,
  output logic [3:0]       low_voltage_headroom_threshold,
  output logic [5:0]       high_rail_undervoltage_threshold,
  output logic             dem_upper_enable,
  output logic             dem_lower_enable,
  output logic             dither_enable,
  output logic [4:0]       limiter_headroom,
  output logic             limiter_headroom_valid
);
  typedef struct packed {
    logic [7:0]  switch_delay;
    logic        low_rail_convert_enable;
    logic [2:0]  detected_sample_rate;
    logic        gate_fine_mode_enable;
    logic [23:0] gate_fine_threshold;
    logic [7:0]  hyst_high;
    logic [7:0]  hyst_low;
    logic [7:0]  tracking;
    logic [7:0]  dac_limiter;
    logic [7:0]  rd_data;
  } stg_regs_state_t;

  stg_regs_state_t st;
  stg_regs_state_t next_st;

  logic [7:0]  rate_gate_byte;
  logic [7:0]  rd_mux;
  logic [1:0]  bridge_switch_delay;
  logic [1:0]  supply_signal_delay;
  logic        rate_is_96k;
  logic [3:0]  bridge_tap;
  logic [3:0]  signal_tap;
  logic [18:0] gate_fine_hysteresis;
  logic        signal_delayed;
  logic        supply_raw;

  assign bridge_switch_delay  = st.switch_delay[7:6];
  assign supply_signal_delay  = st.switch_delay[5:4];
  assign gate_fine_hysteresis = {st.hyst_high, st.hyst_low, 3'b000};

  // mixed register: reserved bits come back as their reset value
  always_comb
  begin
    rate_gate_byte = stg_pkg::RST_RATE_GATE & ~stg_pkg::RATE_GATE_WMASK;
    rate_gate_byte[stg_pkg::POS_CONVERT_EN] = st.low_rail_convert_enable;
    rate_gate_byte[stg_pkg::POS_RATE_LSB +: 3] = st.detected_sample_rate;
    rate_gate_byte[stg_pkg::POS_FINE_EN] = st.gate_fine_mode_enable;
  end

  always_comb
  begin
    unique case (reg_addr)
      stg_pkg::ADDR_SWITCH_DELAY: rd_mux = st.switch_delay;
      stg_pkg::ADDR_RATE_GATE:    rd_mux = rate_gate_byte;
      stg_pkg::ADDR_THRESH_HI:    rd_mux = st.gate_fine_threshold[23:16];
      stg_pkg::ADDR_THRESH_MID:   rd_mux = st.gate_fine_threshold[15:8];
      stg_pkg::ADDR_THRESH_LO:    rd_mux = st.gate_fine_threshold[7:0];
      stg_pkg::ADDR_HYST_HIGH:    rd_mux = st.hyst_high;
      stg_pkg::ADDR_HYST_LOW:     rd_mux = st.hyst_low;
      stg_pkg::ADDR_TRACKING:     rd_mux = st.tracking;
      stg_pkg::ADDR_DAC_LIMITER:  rd_mux = st.dac_limiter;
      default:                    rd_mux = 8'h00;
    endcase
  end

  always_comb
  begin
    next_st = st;
    if (reg_rd_en)
      next_st.rd_data = rd_mux;
    if (reg_wr_en)
    begin
      unique case (reg_addr)
        stg_pkg::ADDR_SWITCH_DELAY: next_st.switch_delay = reg_wr_data;
        stg_pkg::ADDR_RATE_GATE:
        begin
          next_st.low_rail_convert_enable = reg_wr_data[stg_pkg::POS_CONVERT_EN];
          next_st.detected_sample_rate    = reg_wr_data[stg_pkg::POS_RATE_LSB +: 3];
          next_st.gate_fine_mode_enable   = reg_wr_data[stg_pkg::POS_FINE_EN];
        end
        stg_pkg::ADDR_THRESH_HI:    next_st.gate_fine_threshold[23:16] = reg_wr_data;
        stg_pkg::ADDR_THRESH_MID:   next_st.gate_fine_threshold[15:8]  = reg_wr_data;
        stg_pkg::ADDR_THRESH_LO:    next_st.gate_fine_threshold[7:0]   = reg_wr_data;
        stg_pkg::ADDR_HYST_HIGH:    next_st.hyst_high = reg_wr_data;
        stg_pkg::ADDR_HYST_LOW:     next_st.hyst_low  = reg_wr_data;
        stg_pkg::ADDR_TRACKING:     next_st.tracking  = reg_wr_data;
        stg_pkg::ADDR_DAC_LIMITER:  next_st.dac_limiter = reg_wr_data;
        default:                    next_st.rd_data = next_st.rd_data;
      endcase
    end
    // the detector's report wins over a software write in the same cycle
    if (rate_detect_valid)
      next_st.detected_sample_rate = rate_detect_code;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st.switch_delay            <= stg_pkg::RST_SWITCH_DELAY;
      st.low_rail_convert_enable <= stg_pkg::RST_RATE_GATE[stg_pkg::POS_CONVERT_EN];
      st.detected_sample_rate    <= stg_pkg::RATE_ERROR;
      st.gate_fine_mode_enable   <= stg_pkg::RST_RATE_GATE[stg_pkg::POS_FINE_EN];
      st.gate_fine_threshold     <= stg_pkg::RST_THRESHOLD;
      st.hyst_high               <= stg_pkg::RST_HYST_HIGH;
      st.hyst_low                <= stg_pkg::RST_HYST_LOW;
      st.tracking                <= stg_pkg::RST_TRACKING;
      st.dac_limiter             <= stg_pkg::RST_DAC_LIMITER;
      st.rd_data                 <= 8'h00;
    end
    else
      st <= next_st;
  end

  // any rate other than the 96k family uses the 48k timing, including the error code
  assign rate_is_96k = (st.detected_sample_rate == stg_pkg::RATE_96K);

  always_comb
  begin
    unique case ({rate_is_96k, st.gate_fine_mode_enable})
      2'b00: bridge_tap = stg_pkg::tap_pick(stg_pkg::BRIDGE_TAP_48_OFF, bridge_switch_delay);
      2'b01: bridge_tap = stg_pkg::tap_pick(stg_pkg::BRIDGE_TAP_48_ON, bridge_switch_delay);
      2'b10: bridge_tap = stg_pkg::tap_pick(stg_pkg::BRIDGE_TAP_96_OFF, bridge_switch_delay);
      2'b11: bridge_tap = stg_pkg::tap_pick(stg_pkg::BRIDGE_TAP_96_ON, bridge_switch_delay);
    endcase
    unique case ({rate_is_96k, st.gate_fine_mode_enable})
      2'b00: signal_tap = stg_pkg::tap_pick(stg_pkg::SIGNAL_TAP_48_OFF, supply_signal_delay);
      2'b01: signal_tap = stg_pkg::tap_pick(stg_pkg::SIGNAL_TAP_48_ON, supply_signal_delay);
      2'b10: signal_tap = stg_pkg::tap_pick(stg_pkg::SIGNAL_TAP_96_OFF, supply_signal_delay);
      2'b11: signal_tap = stg_pkg::tap_pick(stg_pkg::SIGNAL_TAP_96_ON, supply_signal_delay);
    endcase
  end

  stg_sample_delay stg_sample_delay_i (
    .sys_clk       (sys_clk),
    .rst_b         (rst_b),
    .sample_strobe (sample_strobe),
    .din           (bridge_req_in),
    .tap           (bridge_tap),
    .dout          (bridge_switch_out)
  );

  stg_sample_delay stg_sample_delay_sig_i (
    .sys_clk       (sys_clk),
    .rst_b         (rst_b),
    .sample_strobe (sample_strobe),
    .din           (low_voltage_req_in),
    .tap           (signal_tap),
    .dout          (signal_delayed)
  );

  stg_gate_detect stg_gate_detect_i (
    .sys_clk       (sys_clk),
    .rst_b         (rst_b),
    .sample_strobe (sample_strobe),
    .enable        (st.gate_fine_mode_enable),
    .sample_level  (sample_level),
    .threshold     (st.gate_fine_threshold),
    .hyst_count    (gate_fine_hysteresis),
    .gate_closed   (gate_closed)
  );

  assign tracking_active = st.tracking[stg_pkg::POS_TRACK_EN];
  // pin follows the tracking modulator under class-H, else the delayed low-voltage request
  assign supply_raw      = tracking_active ? tracking_mod_in : signal_delayed;
  assign supply_ctrl_out = supply_raw ^ st.tracking[stg_pkg::POS_POLARITY];

  assign low_rail_convert_req             = !bop_src_high_rail || st.low_rail_convert_enable;
  assign low_voltage_headroom_threshold   = st.switch_delay[3:0];
  assign high_rail_undervoltage_threshold = st.tracking[5:0];
  assign dem_upper_enable                 = !st.dac_limiter[7];
  assign dem_lower_enable                 = !st.dac_limiter[6];
  assign dither_enable                    = !st.dac_limiter[stg_pkg::POS_DITHER_DIS];
  assign limiter_headroom                 = st.dac_limiter[4:0];
  // reserved codes are stored as written but flagged so the limiter can hold its last good value
  assign limiter_headroom_valid           = st.dac_limiter[4:0] <= stg_pkg::HEADROOM_MAX_CODE;
  assign reg_rd_data                      = st.rd_data;

  sequence s_write_delay;
    reg_wr_en && reg_addr == stg_pkg::ADDR_SWITCH_DELAY;
  endsequence

  property p_switch_field;
    @(posedge sys_clk) disable iff (!rst_b)
    s_write_delay |=> bridge_switch_delay == $past(reg_wr_data[7:6])
      && low_voltage_headroom_threshold == $past(reg_wr_data[3:0]);
  endproperty
  a_switch_field: assert property (p_switch_field)
    else $error("switch delay field did not take the write");

  property p_bridge_tap_default;
    @(posedge sys_clk) disable iff (!rst_b)
    bridge_switch_delay == 2'h0 && !rate_is_96k |-> bridge_tap == (st.gate_fine_mode_enable ? 4'h8 : 4'h6);
  endproperty
  a_bridge_tap_default: assert property (p_bridge_tap_default)
    else $error("bridge delay for code 0 is wrong");

  property p_signal_default;
    @(posedge sys_clk) disable iff (!rst_b)
    supply_signal_delay == 2'h1 && !rate_is_96k |-> signal_tap == (st.gate_fine_mode_enable ? 4'h6 : 4'h4);
  endproperty
  a_signal_default: assert property (p_signal_default)
    else $error("supply signal delay for code 1 is wrong");

  property p_convert;
    @(posedge sys_clk) disable iff (!rst_b)
    bop_src_high_rail && !st.low_rail_convert_enable |-> !low_rail_convert_req;
  endproperty
  a_convert: assert property (p_convert)
    else $error("low rail conversion not suppressed");

  property p_rate_detect;
    @(posedge sys_clk) disable iff (!rst_b)
    rate_detect_valid |=> st.detected_sample_rate == $past(rate_detect_code);
  endproperty
  a_rate_detect: assert property (p_rate_detect)
    else $error("detected rate not recorded");

  property p_gate_off;
    @(posedge sys_clk) disable iff (!rst_b)
    !st.gate_fine_mode_enable ##1 !st.gate_fine_mode_enable |-> !gate_closed;
  endproperty
  a_gate_off: assert property (p_gate_off)
    else $error("gate closed while fine mode is off");

  sequence s_read_mixed;
    reg_rd_en && reg_addr == stg_pkg::ADDR_RATE_GATE;
  endsequence

  property p_reserved_read;
    @(posedge sys_clk) disable iff (!rst_b)
    s_read_mixed |=> reg_rd_data[7] == 1'b0 && reg_rd_data[1:0] == 2'h3;
  endproperty
  a_reserved_read: assert property (p_reserved_read)
    else $error("reserved bits did not read their reset value");

  property p_thresh_order;
    @(posedge sys_clk) disable iff (!rst_b)
    reg_rd_en && reg_addr == stg_pkg::ADDR_THRESH_HI |=> reg_rd_data == $past(st.gate_fine_threshold[23:16]);
  endproperty
  a_thresh_order: assert property (p_thresh_order)
    else $error("threshold high byte not at lowest address");

  property p_polarity;
    @(posedge sys_clk) disable iff (!rst_b)
    tracking_active |-> supply_ctrl_out == (tracking_mod_in ^ st.tracking[stg_pkg::POS_POLARITY]);
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("supply control polarity wrong");

  property p_dem;
    @(posedge sys_clk) disable iff (!rst_b)
    reg_wr_en && reg_addr == stg_pkg::ADDR_DAC_LIMITER && reg_wr_data[7:5] == 3'h7
      |=> !dem_upper_enable && !dem_lower_enable && !dither_enable;
  endproperty
  a_dem: assert property (p_dem)
    else $error("element matching or dither not disabled");

  // code 2 at the high rate is 8.5 periods with the gate on, cut to 8
  property p_bridge_tap_96k;
    @(posedge sys_clk) disable iff (!rst_b)
    bridge_switch_delay == 2'h2 && rate_is_96k && st.gate_fine_mode_enable |-> bridge_tap == 4'h8;
  endproperty
  a_bridge_tap_96k: assert property (p_bridge_tap_96k)
    else $error("bridge delay for code 2 at the high rate is wrong");

  property p_signal_path;
    @(posedge sys_clk) disable iff (!rst_b)
    !tracking_active |-> supply_ctrl_out == (signal_delayed ^ st.tracking[stg_pkg::POS_POLARITY]);
  endproperty
  a_signal_path: assert property (p_signal_path)
    else $error("supply control pin not fed by the delayed request");

  property p_convert_pass;
    @(posedge sys_clk) disable iff (!rst_b)
    !bop_src_high_rail |-> low_rail_convert_req;
  endproperty
  a_convert_pass: assert property (p_convert_pass)
    else $error("low rail conversion blocked with the low rail as source");

  sequence s_level_loud;
    sample_strobe && st.gate_fine_mode_enable && sample_level >= st.gate_fine_threshold;
  endsequence

  property p_gate_open;
    @(posedge sys_clk) disable iff (!rst_b)
    s_level_loud |=> !gate_closed;
  endproperty
  a_gate_open: assert property (p_gate_open)
    else $error("gate stayed closed at or above the threshold");

  sequence s_write_tracking;
    reg_wr_en && reg_addr == stg_pkg::ADDR_TRACKING;
  endsequence

  property p_tracking_write;
    @(posedge sys_clk) disable iff (!rst_b)
    s_write_tracking |=> tracking_active == $past(reg_wr_data[stg_pkg::POS_TRACK_EN])
      && high_rail_undervoltage_threshold == $past(reg_wr_data[5:0]);
  endproperty
  a_tracking_write: assert property (p_tracking_write)
    else $error("tracking register did not take the write");

  property p_limiter_reserved;
    @(posedge sys_clk) disable iff (!rst_b)
    reg_wr_en && reg_addr == stg_pkg::ADDR_DAC_LIMITER && reg_wr_data[4:0] > stg_pkg::HEADROOM_MAX_CODE
      |=> !limiter_headroom_valid && limiter_headroom == $past(reg_wr_data[4:0]);
  endproperty
  a_limiter_reserved: assert property (p_limiter_reserved)
    else $error("reserved limiter code not flagged");

  // the one unmapped byte inside the bank, between tracking and limiter
  property p_unmapped_read;
    @(posedge sys_clk) disable iff (!rst_b)
    reg_rd_en && reg_addr == stg_pkg::ADDR_TRACKING + 8'h01 |=> reg_rd_data == 8'h00;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped address did not read zero");
endmodule
`default_nettype wire

// File: test/stg_regs_tb_top.sv
// Purpose: self-checking bench for the supply tracking and noise gate register bank
// Assumes: byte register port, read data registered one cycle after reg_rd_en
// Notes:   delays are compared as differences, so the fixed latency of the shift stage cancels out
`timescale 1ns/1ps
`default_nettype none
module stg_regs_tb_top;
  logic        sys_clk            = 1'b0;
  logic        rst_b              = 1'b0;
  logic [7:0]  reg_addr           = 8'h00;
  logic        reg_wr_en          = 1'b0;
  logic [7:0]  reg_wr_data        = 8'h00;
  logic        reg_rd_en          = 1'b0;
  logic        sample_strobe      = 1'b0;
  logic        rate_detect_valid  = 1'b0;
  logic [2:0]  rate_detect_code   = 3'h0;
  logic [23:0] sample_level       = 24'h000000;
  logic        bridge_req_in      = 1'b0;
  logic        low_voltage_req_in = 1'b0;
  logic        tracking_mod_in    = 1'b0;
  logic        bop_src_high_rail  = 1'b0;
  logic [7:0]  reg_rd_data;
  logic        bridge_switch_out, supply_ctrl_out, tracking_active, gate_closed, low_rail_convert_req;
  logic [3:0]  low_voltage_headroom_threshold;
  logic [5:0]  high_rail_undervoltage_threshold;
  logic        dem_upper_enable, dem_lower_enable, dither_enable, limiter_headroom_valid;
  logic [4:0]  limiter_headroom;
  int          failures = 0;
  int          n_tests  = 0;
  int          m [0:4];
  int          s [0:2];

  always #5 sys_clk = ~sys_clk;

  stg_regs stg_regs_i (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .sample_strobe(sample_strobe), .rate_detect_valid(rate_detect_valid), .rate_detect_code(rate_detect_code),
    .sample_level(sample_level), .bridge_req_in(bridge_req_in), .low_voltage_req_in(low_voltage_req_in),
    .tracking_mod_in(tracking_mod_in), .bop_src_high_rail(bop_src_high_rail),
    .bridge_switch_out(bridge_switch_out), .supply_ctrl_out(supply_ctrl_out),
    .tracking_active(tracking_active), .gate_closed(gate_closed), .low_rail_convert_req(low_rail_convert_req),
    .low_voltage_headroom_threshold(low_voltage_headroom_threshold),
    .high_rail_undervoltage_threshold(high_rail_undervoltage_threshold),
    .dem_upper_enable(dem_upper_enable), .dem_lower_enable(dem_lower_enable), .dither_enable(dither_enable),
    .limiter_headroom(limiter_headroom), .limiter_headroom_valid(limiter_headroom_valid));

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr    <= a;
    reg_wr_data <= d;
    reg_wr_en   <= 1'b1;
    @(posedge sys_clk);
    reg_wr_en   <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_rd_en <= 1'b1;
    @(posedge sys_clk);
    reg_rd_en <= 1'b0;
    #1;
    chk(reg_rd_data, e);
  endtask

  // lets the write edge land before outputs are looked at
  task automatic settle();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic strobe(input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      sample_strobe <= 1'b1;
      @(posedge sys_clk);
      sample_strobe <= 1'b0;
      @(posedge sys_clk);
    end
    #1;
  endtask

  // flushes the line, raises the request and counts strobes until the delayed copy shows
  task automatic measure(input bit sel, output int n);
    @(posedge sys_clk);
    bridge_req_in      <= 1'b0;
    low_voltage_req_in <= 1'b0;
    strobe(14);
    @(posedge sys_clk);
    if (sel)
      low_voltage_req_in <= 1'b1;
    else
      bridge_req_in <= 1'b1;
    n = 0;
    while (n < 30 && (sel ? supply_ctrl_out : bridge_switch_out) !== 1'b1)
    begin
      strobe(1);
      n++;
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    #500000;
    failures++;
    print_verdict();
  end

  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd_chk(8'h6A, 8'h12);
    rd_chk(8'h6B, 8'h7B);
    rd_chk(8'h6C, 8'h00);
    rd_chk(8'h6D, 8'h00);
    rd_chk(8'h6E, 8'h1A);
    rd_chk(8'h6F, 8'h00);
    rd_chk(8'h70, 8'h96);
    rd_chk(8'h71, 8'h02);
    rd_chk(8'h73, 8'h08);
    rd_chk(8'h72, 8'h00);
    chk({tracking_active, gate_closed, dem_upper_enable, dem_lower_enable, dither_enable}, 5'h07);
    chk({low_voltage_headroom_threshold, high_rail_undervoltage_threshold}, 10'h082);
    chk({limiter_headroom_valid, limiter_headroom}, 6'h28);
    $display("test reset_values done");
    // reserved bits of the mixed register hold 0 and 3 whatever is written
    wr(8'h6B, 8'hFF);
    rd_chk(8'h6B, 8'h7F);
    wr(8'h6B, 8'h00);
    rd_chk(8'h6B, 8'h03);
    chk(low_rail_convert_req, 1'b1);
    @(posedge sys_clk);
    bop_src_high_rail <= 1'b1;
    settle();
    chk(low_rail_convert_req, 1'b0);
    wr(8'h6B, 8'h40);
    settle();
    chk(low_rail_convert_req, 1'b1);
    wr(8'h6A, 8'h1F);
    wr(8'h71, 8'h3F);
    rd_chk(8'h6A, 8'h1F);
    chk({low_voltage_headroom_threshold, high_rail_undervoltage_threshold}, 10'h3FF);
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h73, {c[1:0], 6'h08});
      settle();
      chk({dem_upper_enable, dem_lower_enable}, {~c[1], ~c[0]});
    end
    wr(8'h73, 8'hF0);
    settle();
    chk({dither_enable, limiter_headroom_valid, limiter_headroom}, 7'h30);
    chk({dem_upper_enable, dem_lower_enable}, 2'h0);
    wr(8'h73, 8'h11);
    rd_chk(8'h73, 8'h11);
    chk({limiter_headroom_valid, limiter_headroom}, 6'h11);
    for (int p = 0; p < 4; p++)
    begin
      wr(8'h71, {1'b1, p[1], 6'h02});
      @(posedge sys_clk);
      tracking_mod_in <= p[0];
      settle();
      chk({tracking_active, supply_ctrl_out}, {1'b1, p[0] ^ p[1]});
    end
    wr(8'h71, 8'h02);
    $display("test fields done");
    // bridge 6, 3, 8 and supply 4, 3, 6 sample periods, whole periods kept
    measure(0, m[0]);
    measure(1, s[0]);
    wr(8'h6A, 8'hF2);
    measure(0, m[1]);
    measure(1, s[1]);
    wr(8'h6A, 8'h12);
    wr(8'h6B, 8'h44);
    measure(0, m[2]);
    measure(1, s[2]);
    chk(24'(m[0] - m[1]), 24'h000003);
    chk(24'(m[2] - m[0]), 24'h000002);
    chk(24'(m[0] - s[0]), 24'h000002);
    chk(24'(s[0] - s[1]), 24'h000001);
    chk(24'(s[2] - s[0]), 24'h000002);
    @(posedge sys_clk);
    rate_detect_valid <= 1'b1;
    rate_detect_code  <= 3'h5;
    @(posedge sys_clk);
    rate_detect_valid <= 1'b0;
    rd_chk(8'h6B, 8'h6F);
    measure(0, m[3]);
    chk(24'(m[3] - m[2]), 24'h000004);
    // high rate, gate on: code 2 is 8.5 periods, kept as 8
    wr(8'h6A, 8'h92);
    measure(0, m[4]);
    chk(24'(m[3] - m[4]), 24'h000004);
    $display("test delays done");
    // 56 counts stays above one millisecond at 48 ksps
    wr(8'h6B, 8'h40);
    wr(8'h6C, 8'h00);
    wr(8'h6D, 8'h00);
    wr(8'h6E, 8'h10);
    wr(8'h6F, 8'h00);
    wr(8'h70, 8'h07);
    wr(8'h6B, 8'h44);
    strobe(40);
    chk(gate_closed, 1'b0);
    strobe(30);
    chk(gate_closed, 1'b1);
    @(posedge sys_clk);
    sample_level <= 24'h000010;
    strobe(1);
    chk(gate_closed, 1'b0);
    @(posedge sys_clk);
    sample_level <= 24'h00000F;
    strobe(70);
    chk(gate_closed, 1'b1);
    wr(8'h6B, 8'h40);
    settle();
    chk(gate_closed, 1'b0);
    $display("test noise_gate done");
    print_verdict();
  end
endmodule
`default_nettype wire
